// >>> tbp_pkg.sv
// Package with register map, field layout and constants of the motor PWM time base.
package tbp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 15;
  localparam int PRE_W = 6;
  localparam int POST_W = 4;

  // Register indices (byte address is four times the index).
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_COUNT = 6'h01;
  localparam logic [5:0] IDX_PERIOD = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_MASK = 6'h04;
  localparam logic [5:0] IDX_DUTY0 = 6'h05;

  // Control, count and status register fields.
  localparam int CTRL_RUN = 15;
  localparam int CTRL_OPS_LO = 4;
  localparam int CTRL_CKPS_LO = 2;
  localparam int CTRL_MODE_LO = 0;
  localparam int COUNT_DIR = 15;
  localparam int STAT_TB = 0;
  localparam int STAT_W = 1;

  // Reset values.
  localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Prescaler terminal counts for 1:1, 1:4, 1:16 and 1:64.
  localparam logic [PRE_W-1:0] PRE_DIV1 = 6'h00;
  localparam logic [PRE_W-1:0] PRE_DIV4 = 6'h03;
  localparam logic [PRE_W-1:0] PRE_DIV16 = 6'h0F;
  localparam logic [PRE_W-1:0] PRE_DIV64 = 6'h3F;

  typedef enum logic [1:0] {
    TBP_FREE,
    TBP_SINGLE,
    TBP_UPDOWN,
    TBP_DOUBLE
  } tbp_mode_t;

endpackage

// >>> tbp_divider.sv
// Counting divider that turns a stream of step pulses into one tick for every limit plus one steps.
`timescale 1ns/10ps
`default_nettype none
module tbp_divider #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  // Result
  output logic tick
);

  logic [W-1:0] cnt;

  initial begin
    if (W < 1 || W > 16) begin
      $error("tbp_divider width out of range");
    end
  end

  assign tick = step & (cnt >= limit) & ~clear;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (clear || tick) begin
      cnt <= '0;
    end else if (step) begin
      cnt <= W'(cnt + 1'h1);
    end
  end

endmodule
`default_nettype wire

// >>> tbp_time_base.sv
// Motor PWM time base with Wishbone registers, interrupt and one to three output pairs.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tbp_time_base #(
  parameter int PAIRS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tbp_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [tbp_pkg::DATA_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [tbp_pkg::DATA_W-1:0] wb_dat_o,
  // Interrupt and drive outputs
  output logic irq,
  output logic [PAIRS-1:0] pwm_h,
  output logic [PAIRS-1:0] pwm_l
);
  import tbp_pkg::*;

  initial begin
    if (PAIRS < 1 || PAIRS > 3) begin
      $error("tbp_time_base supports one to three output pairs");
    end
  end

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                             input logic [DATA_W-1:0] data,
                                             input logic [3:0] sel);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [PRE_W-1:0] pre_limit(input logic [1:0] sel);
    logic [PRE_W-1:0] res;
    res = PRE_DIV1;
    unique case (sel)
      2'h0: res = PRE_DIV1;
      2'h1: res = PRE_DIV4;
      2'h2: res = PRE_DIV16;
      2'h3: res = PRE_DIV64;
    endcase
    return res;
  endfunction

  logic run;
  tbp_mode_t mode;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic [CNT_W-1:0] time_base_count;
  logic count_down_flag;
  logic [CNT_W-1:0] period_value;
  logic [CNT_W-1:0] period_act;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [CNT_W-1:0] duty [PAIRS];

  logic access, wr, rd;
  logic [5:0] idx;
  logic wr_ctrl, wr_count, wr_period, wr_mask, rd_status;
  logic [DATA_W-1:0] ctrl_val, count_val, rd_val;
  logic [DATA_W-1:0] ctrl_new, count_new, period_new, mask_new;
  logic pre_tick, post_tick, step, at_top, at_zero;
  logic raw_match, raw_zero, raw_evt, post_on, tb_evt, load_pt, div_clear;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = access & wb_we_i;
  assign rd = access & ~wb_we_i;
  assign idx = wb_adr_i[ADDR_W-1:2];
  assign wr_ctrl = wr && idx == IDX_CTRL;
  assign wr_count = wr && idx == IDX_COUNT;
  assign wr_period = wr && idx == IDX_PERIOD;
  assign wr_mask = wr && idx == IDX_MASK;
  assign rd_status = rd && idx == IDX_STATUS;

  assign ctrl_val = {16'h0000, run, 7'h00, postscale_select, prescale_select, mode};
  assign count_val = {16'h0000, count_down_flag, time_base_count};
  assign ctrl_new = merge(ctrl_val, wb_dat_i, wb_sel_i);
  assign count_new = merge(count_val, wb_dat_i, wb_sel_i);
  assign period_new = merge({17'h0_0000, period_value}, wb_dat_i, wb_sel_i);
  assign mask_new = merge({31'h0000_0000, mask}, wb_dat_i, wb_sel_i);

  // Prescaler and postscaler restart on any write to control or count.
  assign div_clear = wr_ctrl | wr_count;

  tbp_divider #(.W(PRE_W)) u_prescale (
    .clk(clk),
    .arst_n(arst_n),
    .clear(div_clear),
    .step(run),
    .limit(pre_limit(prescale_select)),
    .tick(pre_tick)
  );

  // Counting halts outright while the active period is zero.
  assign step = pre_tick & run & (period_act != PERIOD_RST);
  assign at_top = time_base_count == period_act;
  assign at_zero = time_base_count == CNT_RST;
  assign raw_match = step & ~count_down_flag & at_top;
  assign raw_zero = step & count_down_flag & at_zero;

  always_comb begin
    raw_evt = 1'h0;
    post_on = 1'h0;
    load_pt = 1'h0;
    unique case (mode)
      TBP_FREE: begin
        raw_evt = raw_match;
        post_on = 1'h1;
        load_pt = raw_match;
      end
      TBP_SINGLE: begin
        raw_evt = raw_match;
        load_pt = raw_match;
      end
      TBP_UPDOWN: begin
        raw_evt = raw_zero;
        post_on = 1'h1;
        load_pt = raw_zero;
      end
      TBP_DOUBLE: begin
        raw_evt = raw_match | raw_zero;
        load_pt = raw_zero;
      end
    endcase
  end

  tbp_divider #(.W(POST_W)) u_postscale (
    .clk(clk),
    .arst_n(arst_n),
    .clear(div_clear),
    .step(raw_evt & post_on),
    .limit(postscale_select),
    .tick(post_tick)
  );

  assign tb_evt = post_on ? post_tick : raw_evt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'h0;
      mode <= TBP_FREE;
      prescale_select <= 2'h0;
      postscale_select <= 4'h0;
    end else if (wr_ctrl) begin
      run <= ctrl_new[CTRL_RUN];
      mode <= tbp_mode_t'(ctrl_new[CTRL_MODE_LO +: 2]);
      prescale_select <= ctrl_new[CTRL_CKPS_LO +: 2];
      postscale_select <= ctrl_new[CTRL_OPS_LO +: 4];
    end else if (raw_match && mode == TBP_SINGLE) begin
      run <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      time_base_count <= CNT_RST;
      count_down_flag <= 1'h0;
    end else if (wr_count) begin
      time_base_count <= count_new[CNT_W-1:0];
    end else if (step) begin
      if (!count_down_flag) begin
        if (at_top) begin
          if (mode == TBP_UPDOWN || mode == TBP_DOUBLE) begin
            count_down_flag <= 1'h1;
            time_base_count <= CNT_W'(time_base_count - 1'h1);
          end else begin
            time_base_count <= CNT_RST;
          end
        end else begin
          time_base_count <= CNT_W'(time_base_count + 1'h1);
        end
      end else if (at_zero) begin
        count_down_flag <= 1'h0;
        time_base_count <= CNT_W'(time_base_count + 1'h1);
      end else begin
        time_base_count <= CNT_W'(time_base_count - 1'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_value <= PERIOD_RST;
    end else if (wr_period) begin
      period_value <= period_new[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_act <= PERIOD_RST;
    end else if (!run) begin
      period_act <= period_value;
    end else if (load_pt && period_act != PERIOD_RST) begin
      period_act <= period_value;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < PAIRS; i++) begin
        duty[i] <= CNT_RST;
      end
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        if (wr && idx == 6'(IDX_DUTY0 + i)) begin
          duty[i] <= wb_dat_i[CNT_W-1:0];
        end
      end
    end
  end

  // Each high output is active while the count is below its duty value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_h <= '0;
      pwm_l <= '0;
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        pwm_h[i] <= time_base_count < duty[i];
        pwm_l[i] <= !(time_base_count < duty[i]);
      end
    end
  end

  // An event in the same cycle as the clearing read stays set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
      mask <= '0;
      irq <= 1'h0;
    end else begin
      status <= (rd_status ? '0 : status) | STAT_W'(tb_evt);
      if (wr_mask) begin
        mask <= mask_new[STAT_W-1:0];
      end
      irq <= |(status & mask);
    end
  end

  always_comb begin
    rd_val = DATA_ZERO;
    if (idx == IDX_CTRL) begin
      rd_val = ctrl_val;
    end else if (idx == IDX_COUNT) begin
      rd_val = count_val;
    end else if (idx == IDX_PERIOD) begin
      rd_val = {17'h0_0000, period_value};
    end else if (idx == IDX_STATUS) begin
      rd_val = {31'h0000_0000, status};
    end else if (idx == IDX_MASK) begin
      rd_val = {31'h0000_0000, mask};
    end else begin
      for (int i = 0; i < PAIRS; i++) begin
        if (idx == 6'(IDX_DUTY0 + i)) begin
          rd_val = {17'h0_0000, duty[i]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= DATA_ZERO;
    end else begin
      wb_ack_o <= access;
      if (rd) begin
        wb_dat_o <= rd_val;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_up_match;
    step && !count_down_flag && at_top && !wr_count;
  endsequence

  sequence s_down_zero;
    step && count_down_flag && at_zero && !wr_count;
  endsequence

  a_stop_holds: assert property (!run && !wr_count |=> $stable(time_base_count))
    else $error("count moved while stopped");
  a_dir_readback: assert property (rd && idx == IDX_COUNT
    |=> wb_dat_o[COUNT_DIR] == $past(count_down_flag)) else $error("direction flag read wrong");
  a_free_wrap: assert property (s_up_match ##0 (mode == TBP_FREE && !wr_ctrl)
    |=> time_base_count == CNT_RST && run) else $error("free-running count did not wrap");
  a_single_end: assert property (s_up_match ##0 (mode == TBP_SINGLE && !wr_ctrl)
    |=> !run && time_base_count == CNT_RST) else $error("single-shot did not stop");
  a_single_hold: assert property ((!run && !wr_ctrl && !wr_count && at_zero) [*2]
    |-> !tb_evt) else $error("event while halted");
  a_zero_period: assert property (period_act == PERIOD_RST && !wr_count
    |=> $stable(time_base_count) && !$past(tb_evt)) else $error("zero period still counts");
  a_period_stuck: assert property (run && period_act == PERIOD_RST
    |=> period_act == PERIOD_RST) else $error("zero period reloaded while running");
  a_updown_turn: assert property (s_up_match ##0 (mode == TBP_UPDOWN)
    |=> count_down_flag ##0 $past(raw_evt) == 1'h0) else $error("no turn at period match");
  a_double_evts: assert property ((s_up_match or s_down_zero) ##0 (mode == TBP_DOUBLE)
    |-> tb_evt) else $error("double mode event missing");
  a_irq_follow: assert property (tb_evt && mask[STAT_TB] && !wr_mask |-> ##2 irq)
    else $error("interrupt not raised");
  a_pair_inverse: assert property ($past(arst_n) |-> pwm_l == ~pwm_h)
    else $error("low output not complement");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

endmodule
`default_nettype wire

// >>> tbp_gate_drv.sv
// Gate driver model that flags a leg whose two commands are not complementary.
`timescale 1ns/10ps
`default_nettype none
module tbp_gate_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Gate commands
  input wire logic [2:0] pwm_h,
  input wire logic [2:0] pwm_l,
  // Observation
  output logic fault
);
  logic live;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      live <= 1'b0;
      fault <= 1'b0;
    end else begin
      live <= 1'b1;
      if (live && (pwm_l !== ~pwm_h)) begin
        fault <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tbp_time_base_tb.sv
// Self-checking testbench of the motor PWM time base.
`timescale 1ns/10ps
`default_nettype none
module tbp_time_base_tb;
  import tbp_pkg::*;
  logic clk;
  logic arst_n;
  logic cyc;
  logic stb;
  logic we;
  logic [ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [DATA_W-1:0] dat;
  logic ack;
  logic [DATA_W-1:0] rdat;
  logic irq;
  logic [2:0] pwm_h;
  logic [2:0] pwm_l;
  logic fault;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  tbp_time_base #(.PAIRS(3)) tbp_time_base_inst (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .irq(irq), .pwm_h(pwm_h), .pwm_l(pwm_l));
  tbp_gate_drv tbp_gate_drv_inst (.clk(clk), .arst_n(arst_n), .pwm_h(pwm_h), .pwm_l(pwm_l),
    .fault(fault));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(e, q & m);
  endtask

  task automatic t_reset();
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h40, 32'h0000_1234);
    rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h04, 32'h0000_8005);
    rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0005);
    wr(8'h04, 32'h0000_0000);
  endtask

  task automatic t_zero();
    wr(8'h00, 32'h0000_8000);
    wr(8'h08, 32'h0000_0005);
    repeat (30) @(posedge clk);
    rd(8'h04, 32'h0000_7FFF, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_8000);
    repeat (10) @(posedge clk);
    wr(8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0001);
    chk(32'h0000_0000, {31'h0, irq});
  endtask

  task automatic t_free();
    wr(8'h08, 32'h0000_0003);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_80F0);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    repeat (20) @(posedge clk);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    repeat (50) @(posedge clk);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_FFFC, 32'h0000_0000);
  endtask

  task automatic t_single();
    wr(8'h08, 32'h0000_0005);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_80F1);
    repeat (30) @(posedge clk);
    rd(8'h00, 32'h0000_8000, 32'h0000_0000);
    rd(8'h04, 32'h0000_FFFF, 32'h0000_0000);
    chk(32'h0000_0000, {31'h0, irq});
    wr(8'h10, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'h0000_0001, {31'h0, irq});
    rd(8'h0C, 32'h0000_0001, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'h0000_0000, {31'h0, irq});
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
  endtask

  task automatic t_updown();
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_0020);
    wr(8'h00, 32'h0000_80F3);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    repeat (22) @(posedge clk);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    repeat (10) @(posedge clk);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0001);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_8002);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd(8'h0C, 32'h0000_0001, 32'h0000_0000);
    rd(8'h04, 32'h0000_8000, 32'h0000_8000);
    wr(8'h10, 32'h0000_0001);
    repeat (30) @(posedge clk);
    chk(32'h0000_0001, {31'h0, irq});
    rd(8'h0C, 32'h0000_0001, 32'h0000_0001);
    wr(8'h10, 32'h0000_0000);
  endtask

  task automatic t_pre();
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_7FFF);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_800C);
    repeat (150) @(posedge clk);
    wr(8'h00, 32'h0000_000C);
    rd(8'h04, 32'h0000_FFFF, 32'h0000_0002);
    repeat (100) @(posedge clk);
    rd(8'h04, 32'h0000_FFFF, 32'h0000_0002);
    wr(8'h14, 32'h0000_7FFF);
    repeat (3) @(posedge clk);
    chk(32'h0000_0001, {31'h0, pwm_h[0]});
    chk(32'h0000_0000, {31'h0, fault});
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_8004);
    repeat (40) @(posedge clk);
    wr(8'h00, 32'h0000_0004);
    rd(8'h04, 32'h0000_FFFF, 32'h0000_000A);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_8008);
    repeat (40) @(posedge clk);
    wr(8'h00, 32'h0000_0008);
    rd(8'h04, 32'h0000_FFFF, 32'h0000_0002);
  endtask

  initial begin
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0000_0000;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_zero();
    t_free();
    t_single();
    t_updown();
    t_pre();
    summarize();
  end
endmodule
`default_nettype wire
